// ===== common/pfm_map.svh
// Register map, field masks, reset values and pin indices of the port mux
// Operation
// - Boot-select pin is an input with pull-up while reset is held.
// - Boot-select high at reset release selects single-chip flash boot.
// - Boot-select low at reset release selects the internal boot program.
// - Ordinary pins reset with every control bit cleared, nothing driven.
// - Function-select 1 routes first output, function-select 2 the second.
// - Two pins above serial-clock pin reset with direction set.
// - Debug clock pin resets to debug function, pull-down, input enabled.
// - Debug data pin resets to debug function, pull-up, input; two-way.
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH

// Address layout: addr[7:6] selects the port, addr[5:2] the field
`define PFM_PORT_D       2'h0
`define PFM_PORT_E       2'h1
`define PFM_PORT_F       2'h2
`define PFM_PORT_STATUS  2'h3
`define PFM_NUM_PORTS    3
`define PFM_NUM_FIELDS   9

`define PFM_FLD_DATA     4'h0
`define PFM_FLD_DIR      4'h1
`define PFM_FLD_FR1      4'h2
`define PFM_FLD_FR2      4'h3
`define PFM_FLD_OD       4'h4
`define PFM_FLD_PUP      4'h5
`define PFM_FLD_PDN      4'h6
`define PFM_FLD_SEL      4'h7
`define PFM_FLD_IE       4'h8
`define PFM_FLD_BOOT     4'h0

// Implemented pins per port
`define PFM_D_PIN_MASK   8'h3f
`define PFM_E_PIN_MASK   8'h3f
`define PFM_F_PIN_MASK   8'h03
`define PFM_D_SEL_MASK   8'h30

// Pins whose function selects drive a peripheral output
`define PFM_D_FR1_OUT    8'h0f
`define PFM_D_FR2_OUT    8'h0f
`define PFM_F_FR1_OUT    8'h03

// Port E reset values; all other fields reset to zero
`define PFM_E_DIR_RST    8'h0c
`define PFM_E_FR1_RST    8'h30
`define PFM_E_PUP_RST    8'h20
`define PFM_E_PDN_RST    8'h10
`define PFM_E_IE_RST     8'h30

// Pin positions
`define PFM_BOOT_PIN     3
`define PFM_DBG_CLK_PIN  4
`define PFM_DBG_DAT_PIN  5
`define PFM_CAPTURE_PIN  4
`define PFM_D_INT_PIN    5
`define PFM_CS_PIN       0

`define PFM_RESP_OKAY    2'h0
`define PFM_RESP_SLVERR  2'h2

`endif

// ===== common/pfm_pkg.sv
// Types shared by the port mux design
`default_nettype none
package pfm_pkg;
  typedef enum logic {
    PFM_CH_IDLE = 1'b0,
    PFM_CH_RESP = 1'b1
  } pfm_ch_e;

  typedef enum logic {
    PFM_BOOT_ROM   = 1'b0,
    PFM_BOOT_FLASH = 1'b1
  } pfm_boot_e;

  typedef logic [7:0] pfm_byte_t;
endpackage
`default_nettype wire

// ===== rtl/pfm_pin_cell.sv
// One pad: output select, open-drain and debug override, registered drive
`default_nettype none
module pfm_pin_cell (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Configuration
  input  wire logic dir,
  input  wire logic od,
  input  wire logic data,
  input  wire logic alt_sel,
  input  wire logic alt_val,
  // Peripheral that owns direction itself
  input  wire logic ovr_en,
  input  wire logic ovr_val,
  input  wire logic ovr_drive,
  // Pad
  output logic      pad_out,
  output logic      pad_oe_n
);
  logic val;
  logic drive;
  logic pad_out_d;
  logic pad_oe_n_d;

  always_comb begin
    val = alt_sel ? alt_val : data;
    drive = dir;
    if (ovr_en) begin
      val = ovr_val;
      drive = ovr_drive;
    end
    // Open drain only ever pulls low; a high releases the pad
    pad_out_d = od ? 1'b0 : val;
    pad_oe_n_d = !(drive && !(od && val));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
    end else begin
      pad_out <= pad_out_d;
      pad_oe_n <= pad_oe_n_d;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pfm_port_mux.sv
// Pin function mux for ports D, E and F with an AXI4-Lite register slave
//
// Implementation choices: the address map and register access over AXI4-Lite.
`default_nettype none
`include "pfm_map.svh"
module pfm_port_mux (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // AXI4-Lite write address and data
  input  wire logic [7:0] S_AXI_AWADDR,
  input  wire logic       S_AXI_AWVALID,
  output logic            S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0] S_AXI_WSTRB,
  input  wire logic       S_AXI_WVALID,
  output logic            S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]      S_AXI_BRESP,
  output logic            S_AXI_BVALID,
  input  wire logic       S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0] S_AXI_ARADDR,
  input  wire logic       S_AXI_ARVALID,
  output logic            S_AXI_ARREADY,
  output logic [31:0]     S_AXI_RDATA,
  output logic [1:0]      S_AXI_RRESP,
  output logic            S_AXI_RVALID,
  input  wire logic       S_AXI_RREADY,
  // Pads of port D
  input  wire logic [7:0] PD_PIN_IN,
  output logic [7:0]      PD_PIN_OUT,
  output logic [7:0]      PD_PIN_OE_N,
  output logic [7:0]      PD_PULL_UP,
  output logic [7:0]      PD_PULL_DOWN,
  output logic [7:0]      PD_INPUT_LEVEL_SELECT,
  // Pads of port E
  input  wire logic [7:0] PE_PIN_IN,
  output logic [7:0]      PE_PIN_OUT,
  output logic [7:0]      PE_PIN_OE_N,
  output logic [7:0]      PE_PULL_UP,
  output logic [7:0]      PE_PULL_DOWN,
  // Pads of port F
  input  wire logic [7:0] PF_PIN_IN,
  output logic [7:0]      PF_PIN_OUT,
  output logic [7:0]      PF_PIN_OE_N,
  output logic [7:0]      PF_PULL_UP,
  output logic [7:0]      PF_PULL_DOWN,
  // Peripheral outputs to pins
  input  wire logic [7:0] PD_FIRST_FUNCTION_OUT,
  input  wire logic [7:0] PD_SECOND_FUNCTION_OUT,
  input  wire logic [7:0] PF_FIRST_FUNCTION_OUT,
  input  wire logic       DEBUG_DATA_OUT,
  input  wire logic       DEBUG_DATA_DRIVE,
  // Pin levels to peripherals, gated by input enable
  output logic [7:0]      PD_INPUT,
  output logic [7:0]      PE_INPUT,
  output logic [7:0]      PF_INPUT,
  output logic            TIMER_CAPTURE_INPUT,
  output logic [2:0]      EXTERNAL_INTERRUPT_INPUT,
  output logic            SERIAL_CHIP_SELECT_IN,
  output logic            DEBUG_CLOCK_IN,
  output logic            DEBUG_DATA_IN,
  // Boot source
  output logic            BOOT_FROM_FLASH,
  output logic            BOOT_DECIDED
);
  pfm_pkg::pfm_byte_t cfg_q [`PFM_NUM_PORTS][`PFM_NUM_FIELDS];
  pfm_pkg::pfm_byte_t cfg_d [`PFM_NUM_PORTS][`PFM_NUM_FIELDS];
  pfm_pkg::pfm_ch_e   wr_st_q;
  pfm_pkg::pfm_ch_e   wr_st_d;
  pfm_pkg::pfm_ch_e   rd_st_q;
  pfm_pkg::pfm_ch_e   rd_st_d;
  pfm_pkg::pfm_boot_e boot_q;
  pfm_pkg::pfm_boot_e boot_d;
  logic               boot_done_q;
  logic               boot_done_d;
  logic [1:0]         bresp_q;
  logic [1:0]         bresp_d;
  logic [1:0]         rresp_q;
  logic [1:0]         rresp_d;
  logic [31:0]        rdata_q;
  logic [31:0]        rdata_d;
  logic               wr_go;
  logic               rd_go;
  logic [7:0]         pin_in  [`PFM_NUM_PORTS];
  logic [7:0]         pin_out [`PFM_NUM_PORTS];
  logic [7:0]         pin_oen [`PFM_NUM_PORTS];
  logic [7:0]         in_val  [`PFM_NUM_PORTS];
  logic [7:0]         alt_sel [`PFM_NUM_PORTS];
  logic [7:0]         alt_val [`PFM_NUM_PORTS];
  logic [7:0]         ovr_en  [`PFM_NUM_PORTS];
  logic [7:0]         e_pup;
  logic [7:0]         e_ie;

  // Writable bits of one field; unimplemented pins stay zero
  function automatic pfm_pkg::pfm_byte_t fld_mask(input logic [1:0] p,
                                                  input logic [3:0] f);
    pfm_pkg::pfm_byte_t m;
    m = 8'h00;
    if (f < 4'(`PFM_NUM_FIELDS)) begin
      unique case (p)
        `PFM_PORT_D: m = (f == `PFM_FLD_SEL) ? `PFM_D_SEL_MASK
                                            : `PFM_D_PIN_MASK;
        `PFM_PORT_E: m = (f == `PFM_FLD_SEL) ? 8'h00 : `PFM_E_PIN_MASK;
        `PFM_PORT_F: m = (f == `PFM_FLD_SEL) ? 8'h00 : `PFM_F_PIN_MASK;
        `PFM_PORT_STATUS: m = 8'h00;
      endcase
    end
    return m;
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    return (a[7:6] != `PFM_PORT_STATUS) && (a[5:2] < 4'(`PFM_NUM_FIELDS));
  endfunction

  // Write channel: address and data are taken together
  assign wr_go = (wr_st_q == pfm_pkg::PFM_CH_IDLE) && S_AXI_AWVALID
                 && S_AXI_WVALID;
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY = wr_go;
  assign S_AXI_BVALID = (wr_st_q == pfm_pkg::PFM_CH_RESP);
  assign S_AXI_BRESP = bresp_q;

  always_comb begin
    wr_st_d = wr_st_q;
    bresp_d = bresp_q;
    cfg_d = cfg_q;
    unique case (wr_st_q)
      pfm_pkg::PFM_CH_IDLE: begin
        if (wr_go) begin
          wr_st_d = pfm_pkg::PFM_CH_RESP;
          bresp_d = addr_hit(S_AXI_AWADDR) ? `PFM_RESP_OKAY
                                           : `PFM_RESP_SLVERR;
          if (addr_hit(S_AXI_AWADDR) && S_AXI_WSTRB[0]) begin
            cfg_d[S_AXI_AWADDR[7:6]][S_AXI_AWADDR[5:2]] =
              S_AXI_WDATA[7:0]
              & fld_mask(S_AXI_AWADDR[7:6], S_AXI_AWADDR[5:2]);
          end
        end
      end
      pfm_pkg::PFM_CH_RESP: begin
        if (S_AXI_BREADY) begin
          wr_st_d = pfm_pkg::PFM_CH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_st_q <= pfm_pkg::PFM_CH_IDLE;
      bresp_q <= `PFM_RESP_OKAY;
      for (int p = 0; p < `PFM_NUM_PORTS; p++) begin
        for (int f = 0; f < `PFM_NUM_FIELDS; f++) begin
          cfg_q[p][f] <= 8'h00;
        end
      end
      cfg_q[`PFM_PORT_E][`PFM_FLD_DIR] <= `PFM_E_DIR_RST;
      cfg_q[`PFM_PORT_E][`PFM_FLD_FR1] <= `PFM_E_FR1_RST;
      cfg_q[`PFM_PORT_E][`PFM_FLD_PDN] <= `PFM_E_PDN_RST;
      cfg_q[`PFM_PORT_E][`PFM_FLD_PUP] <= `PFM_E_PUP_RST;
      cfg_q[`PFM_PORT_E][`PFM_FLD_IE] <= `PFM_E_IE_RST;
    end else begin
      wr_st_q <= wr_st_d;
      bresp_q <= bresp_d;
      cfg_q <= cfg_d;
    end
  end

  // Read channel; the data field returns the pin level where input is on
  assign rd_go = (rd_st_q == pfm_pkg::PFM_CH_IDLE) && S_AXI_ARVALID;
  assign S_AXI_ARREADY = (rd_st_q == pfm_pkg::PFM_CH_IDLE);
  assign S_AXI_RVALID = (rd_st_q == pfm_pkg::PFM_CH_RESP);
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  always_comb begin
    logic [1:0] p;
    logic [3:0] f;
    p = S_AXI_ARADDR[7:6];
    f = S_AXI_ARADDR[5:2];
    rd_st_d = rd_st_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    unique case (rd_st_q)
      pfm_pkg::PFM_CH_IDLE: begin
        if (rd_go) begin
          rd_st_d = pfm_pkg::PFM_CH_RESP;
          rdata_d = 32'h0000_0000;
          rresp_d = `PFM_RESP_OKAY;
          if (p == `PFM_PORT_STATUS) begin
            if (f == `PFM_FLD_BOOT) begin
              rdata_d[1:0] = {boot_done_q, boot_q};
            end else begin
              rresp_d = `PFM_RESP_SLVERR;
            end
          end else if (!addr_hit(S_AXI_ARADDR)) begin
            rresp_d = `PFM_RESP_SLVERR;
          end else if (f == `PFM_FLD_DATA) begin
            rdata_d[7:0] = ((cfg_q[p][`PFM_FLD_IE] & in_val[p])
                           | (~cfg_q[p][`PFM_FLD_IE] & cfg_q[p][f]))
                           & fld_mask(p, f);
          end else begin
            rdata_d[7:0] = cfg_q[p][f];
          end
        end
      end
      pfm_pkg::PFM_CH_RESP: begin
        if (S_AXI_RREADY) begin
          rd_st_d = pfm_pkg::PFM_CH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rd_st_q <= pfm_pkg::PFM_CH_IDLE;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PFM_RESP_OKAY;
    end else begin
      rd_st_q <= rd_st_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Boot strap: the pin level follows the pad while reset is held, so the
  // value standing at release is the one that was pulled up meanwhile
  always_comb begin
    boot_d = boot_q;
    boot_done_d = boot_done_q;
    if (RST) begin
      boot_d = PE_PIN_IN[`PFM_BOOT_PIN] ? pfm_pkg::PFM_BOOT_FLASH
                                        : pfm_pkg::PFM_BOOT_ROM;
    end else begin
      boot_done_d = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    boot_q <= boot_d;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      boot_done_q <= 1'b0;
    end else begin
      boot_done_q <= boot_done_d;
    end
  end

  assign BOOT_FROM_FLASH = (boot_q == pfm_pkg::PFM_BOOT_FLASH);
  assign BOOT_DECIDED = boot_done_q;

  // Pad routing
  always_comb begin
    e_pup = cfg_q[`PFM_PORT_E][`PFM_FLD_PUP];
    e_ie = cfg_q[`PFM_PORT_E][`PFM_FLD_IE];
    e_pup[`PFM_BOOT_PIN] = e_pup[`PFM_BOOT_PIN] | RST;
    e_ie[`PFM_BOOT_PIN] = e_ie[`PFM_BOOT_PIN] | RST;
    pin_in[`PFM_PORT_D] = PD_PIN_IN;
    pin_in[`PFM_PORT_E] = PE_PIN_IN;
    pin_in[`PFM_PORT_F] = PF_PIN_IN;
    in_val[`PFM_PORT_D] = pin_in[`PFM_PORT_D] & cfg_q[`PFM_PORT_D][`PFM_FLD_IE];
    in_val[`PFM_PORT_E] = pin_in[`PFM_PORT_E] & e_ie;
    in_val[`PFM_PORT_F] = pin_in[`PFM_PORT_F] & cfg_q[`PFM_PORT_F][`PFM_FLD_IE];
    alt_sel[`PFM_PORT_D] =
      (cfg_q[`PFM_PORT_D][`PFM_FLD_FR1] & `PFM_D_FR1_OUT)
      | (cfg_q[`PFM_PORT_D][`PFM_FLD_FR2] & `PFM_D_FR2_OUT);
    alt_val[`PFM_PORT_D] =
      (cfg_q[`PFM_PORT_D][`PFM_FLD_FR1] & PD_FIRST_FUNCTION_OUT)
      | (~cfg_q[`PFM_PORT_D][`PFM_FLD_FR1]
         & PD_SECOND_FUNCTION_OUT);
    alt_sel[`PFM_PORT_E] = 8'h00;
    alt_val[`PFM_PORT_E] = 8'h00;
    alt_sel[`PFM_PORT_F] =
      cfg_q[`PFM_PORT_F][`PFM_FLD_FR1] & `PFM_F_FR1_OUT;
    alt_val[`PFM_PORT_F] = PF_FIRST_FUNCTION_OUT;
    ovr_en[`PFM_PORT_D] = 8'h00;
    ovr_en[`PFM_PORT_F] = 8'h00;
    ovr_en[`PFM_PORT_E] = 8'h00;
    ovr_en[`PFM_PORT_E][`PFM_DBG_DAT_PIN] =
      cfg_q[`PFM_PORT_E][`PFM_FLD_FR1][`PFM_DBG_DAT_PIN];
  end

  for (genvar p = 0; p < `PFM_NUM_PORTS; p++) begin : g_port
    for (genvar b = 0; b < 8; b++) begin : g_pin
      pfm_pin_cell u_cell (
        .clk       (CLK),
        .rst       (RST),
        .dir       (cfg_q[p][`PFM_FLD_DIR][b]),
        .od        (cfg_q[p][`PFM_FLD_OD][b]),
        .data      (cfg_q[p][`PFM_FLD_DATA][b]),
        .alt_sel   (alt_sel[p][b]),
        .alt_val   (alt_val[p][b]),
        .ovr_en    (ovr_en[p][b]),
        .ovr_val   (DEBUG_DATA_OUT),
        .ovr_drive (DEBUG_DATA_DRIVE),
        .pad_out   (pin_out[p][b]),
        .pad_oe_n  (pin_oen[p][b])
      );
    end
  end

  assign PD_PIN_OUT = pin_out[`PFM_PORT_D];
  assign PE_PIN_OUT = pin_out[`PFM_PORT_E];
  assign PF_PIN_OUT = pin_out[`PFM_PORT_F];
  assign PD_PIN_OE_N = pin_oen[`PFM_PORT_D];
  assign PE_PIN_OE_N = pin_oen[`PFM_PORT_E];
  assign PF_PIN_OE_N = pin_oen[`PFM_PORT_F];
  assign PD_PULL_UP = cfg_q[`PFM_PORT_D][`PFM_FLD_PUP];
  assign PE_PULL_UP = e_pup;
  assign PF_PULL_UP = cfg_q[`PFM_PORT_F][`PFM_FLD_PUP];
  assign PD_PULL_DOWN = cfg_q[`PFM_PORT_D][`PFM_FLD_PDN];
  assign PE_PULL_DOWN = cfg_q[`PFM_PORT_E][`PFM_FLD_PDN];
  assign PF_PULL_DOWN = cfg_q[`PFM_PORT_F][`PFM_FLD_PDN];
  assign PD_INPUT_LEVEL_SELECT = cfg_q[`PFM_PORT_D][`PFM_FLD_SEL];

  // Peripheral inputs see the pad only where input is enabled
  assign PD_INPUT = in_val[`PFM_PORT_D];
  assign PE_INPUT = in_val[`PFM_PORT_E];
  assign PF_INPUT = in_val[`PFM_PORT_F];
  assign TIMER_CAPTURE_INPUT = in_val[`PFM_PORT_D][`PFM_CAPTURE_PIN]
    & cfg_q[`PFM_PORT_D][`PFM_FLD_FR1][`PFM_CAPTURE_PIN];
  // Interrupt inputs need no function select
  assign EXTERNAL_INTERRUPT_INPUT = {in_val[`PFM_PORT_F][1:0],
    in_val[`PFM_PORT_D][`PFM_D_INT_PIN]};
  assign SERIAL_CHIP_SELECT_IN = in_val[`PFM_PORT_F][`PFM_CS_PIN]
    & cfg_q[`PFM_PORT_F][`PFM_FLD_FR2][`PFM_CS_PIN];
  assign DEBUG_CLOCK_IN = in_val[`PFM_PORT_E][`PFM_DBG_CLK_PIN]
    & cfg_q[`PFM_PORT_E][`PFM_FLD_FR1][`PFM_DBG_CLK_PIN];
  assign DEBUG_DATA_IN = in_val[`PFM_PORT_E][`PFM_DBG_DAT_PIN]
    & cfg_q[`PFM_PORT_E][`PFM_FLD_FR1][`PFM_DBG_DAT_PIN];
endmodule
`default_nettype wire

// ===== verif/pfm_port_mux_assertions.sv
// Concurrent checks on the port mux pins and register bus
`default_nettype none
module pfm_port_mux_checker (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST,
  // Register bus handshakes
  input wire logic       S_AXI_AWVALID,
  input wire logic       S_AXI_AWREADY,
  input wire logic       S_AXI_BVALID,
  input wire logic       S_AXI_BREADY,
  input wire logic       S_AXI_ARVALID,
  input wire logic       S_AXI_ARREADY,
  input wire logic       S_AXI_RVALID,
  input wire logic       S_AXI_RREADY,
  // Port D
  input wire logic [7:0] PD_PIN_IN,
  input wire logic [7:0] PD_PIN_OE_N,
  input wire logic [7:0] PD_PULL_UP,
  input wire logic [7:0] PD_INPUT,
  // Port E
  input wire logic [7:0] PE_PIN_IN,
  input wire logic [7:0] PE_PIN_OE_N,
  input wire logic [7:0] PE_PULL_UP,
  input wire logic [7:0] PE_PULL_DOWN,
  // Peripheral side
  input wire logic       TIMER_CAPTURE_INPUT,
  input wire logic       BOOT_FROM_FLASH
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  a_boot_pullup: assert property ($fell(RST) |-> $past(PE_PULL_UP[3]))
    else $error("boot pin not pulled up in reset");
  a_boot_sample: assert property ($fell(RST) |->
    BOOT_FROM_FLASH == $past(PE_PIN_IN[3]))
    else $error("boot source not taken at release");
  a_boot_frozen: assert property (
    !$fell(RST) |-> $stable(BOOT_FROM_FLASH))
    else $error("boot source moved after release");
  a_reset_clear: assert property ($fell(RST) |->
    PD_PIN_OE_N == 8'hff && PD_PULL_UP == 8'h00 && PD_INPUT == 8'h00)
    else $error("port D not idle after reset");
  a_debug_pulls: assert property ($fell(RST) |->
    PE_PULL_UP == 8'h20 && PE_PULL_DOWN == 8'h10)
    else $error("debug pin pulls wrong after reset");
  a_dir_reset: assert property ($fell(RST) |=>
    PE_PIN_OE_N[5:2] == 4'hc)
    else $error("port E drive wrong after reset");
  a_input_gate: assert property ((PD_INPUT & ~PD_PIN_IN) == 8'h00)
    else $error("port D input not from pad");
  a_capture_gate: assert property (
    TIMER_CAPTURE_INPUT |-> PD_PIN_IN[4])
    else $error("capture input without pad level");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=>
    S_AXI_BVALID)
    else $error("write response late");
  a_write_close: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
    !S_AXI_BVALID)
    else $error("write response not retired");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID)
    else $error("read data late");
  a_read_close: assert property (S_AXI_RVALID && S_AXI_RREADY |=>
    !S_AXI_RVALID)
    else $error("read data not retired");
endmodule
bind pfm_port_mux pfm_port_mux_checker chk_u (.*);
`default_nettype wire

// ===== verif/pfm_pad_model.sv
// Pad and external line model for one eight-pin port
`default_nettype none
module pfm_pad_model (
  // Clock
  input  wire logic       clk,
  // Device side of the pads
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] pd,
  // External driver
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // Resolved level
  output logic      [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;
  // Floating lines toggle so a stale level never passes for data
  always @(posedge clk) last_q <= pin;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n[i]) pin[i] = out[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (pu[i]) pin[i] = 1'b1;
      else if (pd[i]) pin[i] = 1'b0;
      else pin[i] = ~last_q[i];
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the port function mux
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] r;
    logic [1:0]  br;
    logic [1:0]  rr;
  } pfm_row_s;
  logic CLK, RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, S_AXI_RREADY, DEBUG_DATA_OUT, DEBUG_DATA_DRIVE;
  logic TIMER_CAPTURE_INPUT, SERIAL_CHIP_SELECT_IN, BOOT_FROM_FLASH;
  logic DEBUG_CLOCK_IN, DEBUG_DATA_IN, BOOT_DECIDED;
  logic [7:0] PD_INPUT_LEVEL_SELECT, PE_INPUT, PF_INPUT;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
  logic [2:0] EXTERNAL_INTERRUPT_INPUT;
  logic [3:0] S_AXI_WSTRB;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdat;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, PD_INPUT;
  logic [7:0] PD_PIN_IN, PD_PIN_OUT, PD_PIN_OE_N, PD_PULL_UP, PD_PULL_DOWN;
  logic [7:0] PE_PIN_IN, PE_PIN_OUT, PE_PIN_OE_N, PE_PULL_UP, PE_PULL_DOWN;
  logic [7:0] PF_PIN_IN, PF_PIN_OUT, PF_PIN_OE_N, PF_PULL_UP, PF_PULL_DOWN;
  logic [7:0] PD_FIRST_FUNCTION_OUT, PD_SECOND_FUNCTION_OUT;
  logic [7:0] PF_FIRST_FUNCTION_OUT;
  logic [7:0] xe[3];
  logic [7:0] xv[3];
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  pfm_row_s rows[9] = '{
    '{8'h04, 32'hff, 32'h3f, 2'h0, 2'h0},
    '{8'h18, 32'hff, 32'h3f, 2'h0, 2'h0},
    '{8'h94, 32'hff, 32'h03, 2'h0, 2'h0},
    '{8'h1c, 32'hff, 32'h30, 2'h0, 2'h0},
    '{8'h54, 32'h0f, 32'h0f, 2'h0, 2'h0},
    '{8'ha0, 32'hff, 32'h03, 2'h0, 2'h0},
    '{8'h10, 32'haa, 32'h2a, 2'h0, 2'h0},
    '{8'h24, 32'hff, 32'h00, 2'h2, 2'h2},
    '{8'hc0, 32'h00, 32'h03, 2'h2, 2'h0}};
  logic [7:0] ra[14] = '{8'h44, 8'h48, 8'h54, 8'h58, 8'h60, 8'h4c, 8'h50,
    8'h00, 8'h04, 8'h08, 8'h10, 8'h1c, 8'h84, 8'ha0};
  logic [7:0] rv[14] = '{8'h0c, 8'h30, 8'h20, 8'h10, 8'h30, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  pfm_port_mux dut_u (.*);
  pfm_pad_model pad_d (.clk(CLK), .oe_n(PD_PIN_OE_N), .out(PD_PIN_OUT),
    .pu(PD_PULL_UP), .pd(PD_PULL_DOWN), .ext_en(xe[0]), .ext_val(xv[0]),
    .pin(PD_PIN_IN));
  pfm_pad_model pad_e (.clk(CLK), .oe_n(PE_PIN_OE_N), .out(PE_PIN_OUT),
    .pu(PE_PULL_UP), .pd(PE_PULL_DOWN), .ext_en(xe[1]), .ext_val(xv[1]),
    .pin(PE_PIN_IN));
  pfm_pad_model pad_f (.clk(CLK), .oe_n(PF_PIN_OE_N), .out(PF_PIN_OUT),
    .pu(PF_PULL_UP), .pd(PF_PULL_DOWN), .ext_en(xe[2]), .ext_val(xv[2]),
    .pin(PF_PIN_IN));

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task done(input string n);
    $display("test %s done", n);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge CLK);
      if (aw && S_AXI_AWREADY === 1'b1) begin
        aw = 1'b0;
        S_AXI_AWVALID <= 1'b0;
      end
      if (w && S_AXI_WREADY === 1'b1) begin
        w = 1'b0;
        S_AXI_WVALID <= 1'b0;
      end
    end
    while (S_AXI_BVALID !== 1'b1) @(posedge CLK);
    resp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK); while (S_AXI_RVALID !== 1'b1);
    rdat = S_AXI_RDATA;
    resp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask

  // Pad changes land one edge after the config edge
  task settle;
    repeat (2) @(posedge CLK);
    #1;
  endtask

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Run takes under two hundred cycles; the ceiling leaves wide margin
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      complete_run;
    end
  end

  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 3'h0;
    {S_AXI_ARVALID, S_AXI_RREADY, DEBUG_DATA_OUT, DEBUG_DATA_DRIVE} = 4'h0;
    S_AXI_AWADDR = 8'h00;
    S_AXI_ARADDR = 8'h00;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hf;
    PD_FIRST_FUNCTION_OUT = 8'h00;
    PD_SECOND_FUNCTION_OUT = 8'h00;
    PF_FIRST_FUNCTION_OUT = 8'h00;
    xe = '{8'h00, 8'h00, 8'h00};
    xv = '{8'h00, 8'h00, 8'h00};
    RST = 1'b1;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    #1;
    chk(BOOT_FROM_FLASH, 32'h1);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk(resp, rows[i].br);
      rd(rows[i].a);
      chk(rdat, rows[i].r);
      chk(resp, rows[i].rr);
    end
    chk({PD_PULL_DOWN, PF_PULL_UP, PF_PULL_DOWN}, 32'h3f0300);
    chk(PD_INPUT_LEVEL_SELECT, 32'h30);
    done("rows");
    // Second reset with the boot pin held low from outside
    @(posedge CLK);
    xe[1] <= 8'h08;
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    chk(PE_PULL_UP[3], 32'h1);
    chk(PE_PIN_OE_N[3], 32'h1);
    chk(BOOT_DECIDED, 32'h0);
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    xe[1] <= 8'h00;
    @(posedge CLK);
    #1;
    chk(BOOT_FROM_FLASH, 32'h0);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(rdat, rv[i]);
    end
    rd(8'hc0);
    chk(rdat, 32'h2);
    chk(BOOT_DECIDED, 32'h1);
    done("reset");
    // Debug pins: pulls alone set the idle levels, then the debug side drives
    chk({DEBUG_CLOCK_IN, DEBUG_DATA_IN}, 32'h1);
    xe[1] <= 8'h10;
    xv[1] <= 8'h10;
    DEBUG_DATA_OUT <= 1'b1;
    DEBUG_DATA_DRIVE <= 1'b1;
    settle;
    chk({DEBUG_CLOCK_IN, PE_PIN_OE_N[5], PE_PIN_OUT[5]}, 32'h5);
    chk(PE_INPUT, 32'h30);
    DEBUG_DATA_DRIVE <= 1'b0;
    xe[1] <= 8'h00;
    done("debug");
    wr(8'h04, 32'h01);
    wr(8'h00, 32'h01);
    settle;
    chk({PD_PIN_OE_N[0], PD_PIN_OUT[0]}, 32'h1);
    wr(8'h10, 32'h01);
    settle;
    chk(PD_PIN_OE_N[0], 32'h1);
    wr(8'h10, 32'h00);
    wr(8'h00, 32'h00);
    PD_FIRST_FUNCTION_OUT <= 8'h01;
    wr(8'h08, 32'h01);
    settle;
    chk({PD_PIN_OE_N[0], PD_PIN_OUT[0]}, 32'h1);
    wr(8'h08, 32'h00);
    PD_FIRST_FUNCTION_OUT <= 8'h00;
    PD_SECOND_FUNCTION_OUT <= 8'h01;
    wr(8'h0c, 32'h01);
    settle;
    chk({PD_PIN_OE_N[0], PD_PIN_OUT[0]}, 32'h1);
    done("output");
    wr(8'h0c, 32'h00);
    wr(8'h04, 32'h00);
    wr(8'h08, 32'h10);
    wr(8'h20, 32'h30);
    xe[0] <= 8'h30;
    xv[0] <= 8'h30;
    settle;
    chk(TIMER_CAPTURE_INPUT, 32'h1);
    chk(PD_INPUT, 32'h30);
    wr(8'ha0, 32'h01);
    xe[2] <= 8'h01;
    xv[2] <= 8'h01;
    settle;
    chk(EXTERNAL_INTERRUPT_INPUT, 32'h3);
    chk(PF_INPUT, 32'h1);
    wr(8'h8c, 32'h01);
    settle;
    chk(SERIAL_CHIP_SELECT_IN, 32'h1);
    wr(8'h8c, 32'h00);
    wr(8'ha0, 32'h00);
    wr(8'h88, 32'h01);
    wr(8'h84, 32'h01);
    PF_FIRST_FUNCTION_OUT <= 8'h01;
    xe[2] <= 8'h00;
    settle;
    chk({PF_PIN_OE_N[0], PF_PIN_OUT[0]}, 32'h1);
    done("inputs");
    complete_run;
  end
endmodule
`default_nettype wire
